// File: include/pbas_map.vh
// How it works
// - after that write the address bits the region cannot use read zero, from bit 4 up for memory and bit 2 up for I/O.
// - a region of registers 1 to 4 whose boot value enables no address bit reads all zeros, sizing write or not.
// - register 0 powers up as a 128-byte I/O region and reads FFFFFF81h after sizing.
// - memory address bits 31:4 are writable and decoded only where enabled.
// - registers 1 to 4 get their per-bit address enables from the boot memory load.
// - bit 3 prefetchable is read only, reset, then boot loaded, always 0 in register 0, and forces all byte enables on a hit.
// - a hit on a prefetchable memory region returns all bytes whatever the byte enables.
// - bits 2:1 give the memory type: 00 anywhere, 01 below 1 MB, 10 64-bit unsupported, 11 reserved.
// - bit 2 of a memory region always reads zero; the type bit of registers 1 to 4 is reset then boot loaded.
// - bit 0 reads 0 for a memory region.
// - bit 0 reads 1 for an I/O region, whose address bits start at bit 2.
`ifndef PBAS_MAP_VH
`define PBAS_MAP_VH
`define PBAS_NUM_BARS 5
`define PBAS_IDX_W 3
`define PBAS_BIT_SPACE 0
`define PBAS_BIT_TYPE 1
`define PBAS_BIT_TYPE64 2
`define PBAS_BIT_PF 3
`define PBAS_MEM_ADDR_MASK 32'hFFFF_FFF0
`define PBAS_IO_ADDR_MASK 32'hFFFF_FFFC
`define PBAS_BAR0_MASK 32'hFFFF_FF80
`define PBAS_ZERO32 32'h0000_0000
`define PBAS_BE_ALL 4'hF
`define PBAS_REG_W 32
`define PBAS_BYTE_W 8
`define PBAS_LANES 4
`define PBAS_ATTR_W 4
`define PBAS_ATTR_IO_RST 4'h1
`define PBAS_ATTR_MEM_RST 4'h0
`define PBAS_IO_FLAG 32'h0000_0001
`endif

// File: src/pbas_top.v
`timescale 1ns/1ps
`include "pbas_map.vh"
module pbas_top #(
    parameter NUM_BARS = `PBAS_NUM_BARS
) (
    // clock, reset, enable
    input wire CLK,
    input wire RESET,
    input wire CE,
    // configuration cycles from the pci target
    input wire CFG_WR,
    input wire CFG_RD,
    input wire [`PBAS_IDX_W-1:0] CFG_IDX,
    input wire [3:0] CFG_BE,
    input wire [31:0] CFG_WDATA,
    output reg [31:0] CFG_RDATA,
    output reg CFG_RVALID,
    // boot memory loader
    input wire BOOT_WR,
    input wire [`PBAS_IDX_W-1:0] BOOT_IDX,
    input wire [31:0] BOOT_DATA,
    // target access decode
    input wire [31:0] ACC_ADDR,
    input wire ACC_IO,
    input wire [3:0] ACC_BE,
    output wire [NUM_BARS-1:0] ACC_HIT,
    output wire [3:0] ACC_BE_EFF
);

    localparam REG_W = `PBAS_REG_W;
    localparam BYTE_W = `PBAS_BYTE_W;
    localparam LANES = `PBAS_LANES;

    // a region with no enabled address bit is disabled
    function region_on;
        input [31:0] mask;
        begin
            region_on = (mask != `PBAS_ZERO32);
        end
    endfunction

    // register number decode, shared by the bus and the boot loader
    function idx_match;
        input [`PBAS_IDX_W-1:0] idx;
        input integer n;
        begin
            idx_match = (idx == n);
        end
    endfunction

    // address enables of a boot value; the low attribute bits never take part in decode
    function [31:0] boot_mask_of;
        input [31:0] boot;
        begin
            if (boot[`PBAS_BIT_SPACE]) begin
                boot_mask_of = boot & `PBAS_IO_ADDR_MASK;
            end else begin
                boot_mask_of = boot & `PBAS_MEM_ADDR_MASK;
            end
        end
    endfunction

    // attribute bits of a boot value; bit 2 stays low since 64-bit placement is not offered
    function [`PBAS_ATTR_W-1:0] boot_attr_of;
        input [31:0] boot;
        input first;
        begin
            boot_attr_of = `PBAS_ATTR_MEM_RST;
            boot_attr_of[`PBAS_BIT_SPACE] = boot[`PBAS_BIT_SPACE];
            boot_attr_of[`PBAS_BIT_TYPE] = boot[`PBAS_BIT_TYPE];
            boot_attr_of[`PBAS_BIT_TYPE64] = 1'b0;
            boot_attr_of[`PBAS_BIT_PF] = first ? 1'b0 : boot[`PBAS_BIT_PF];
        end
    endfunction

    // one byte lane of a bus write; bits without an enable keep reading zero
    function [`PBAS_BYTE_W-1:0] lane_write;
        input [31:0] wdata;
        input [31:0] mask;
        input integer lane;
        reg [31:0] kept;
        begin
            kept = wdata & mask;
            lane_write = kept[`PBAS_BYTE_W*lane +: `PBAS_BYTE_W];
        end
    endfunction

    // an access hits where every enabled address bit matches the stored base
    function addr_match;
        input [31:0] addr;
        input [31:0] base;
        input [31:0] mask;
        begin
            addr_match = (((addr ^ base) & mask) == `PBAS_ZERO32);
        end
    endfunction

    // register view as configuration software reads it
    function [31:0] bar_view;
        input [31:0] mask;
        input [31:0] base;
        input [`PBAS_ATTR_W-1:0] attr;
        begin
            if (!region_on(mask)) begin
                bar_view = `PBAS_ZERO32;
            end else if (attr[`PBAS_BIT_SPACE]) begin
                bar_view = (base & mask & `PBAS_IO_ADDR_MASK) | `PBAS_IO_FLAG;
            end else begin
                bar_view = base & mask & `PBAS_MEM_ADDR_MASK;
                bar_view[`PBAS_BIT_PF] = attr[`PBAS_BIT_PF];
                bar_view[`PBAS_BIT_TYPE] = attr[`PBAS_BIT_TYPE];
                bar_view[`PBAS_BIT_TYPE64] = 1'b0;
            end
        end
    endfunction

    wire [REG_W*NUM_BARS-1:0] view_flat;
    wire [NUM_BARS-1:0] pf_hit;
    wire any_pf;
    reg [31:0] rd_view;

    genvar g;
    genvar l;
    generate
        for (g = 0; g < NUM_BARS; g = g + 1) begin : bar
            reg [31:0] mask_q;
            reg [`PBAS_ATTR_W-1:0] attr_q;
            wire [31:0] base_w;
            wire sel_wr;
            wire sel_boot;
            wire [31:0] boot_mask;
            wire [`PBAS_ATTR_W-1:0] boot_attr;
            wire space_ok;
            wire addr_ok;

            assign sel_wr = CFG_WR && idx_match(CFG_IDX, g);
            assign sel_boot = BOOT_WR && idx_match(BOOT_IDX, g);
            assign boot_mask = boot_mask_of(BOOT_DATA);
            assign boot_attr = boot_attr_of(BOOT_DATA, g == 0);

            // register 0 keeps its fixed size; a boot value changes its space and type and clears its base
            always @(posedge CLK or posedge RESET) begin
                if (RESET) begin
                    if (g == 0) begin
                        mask_q <= `PBAS_BAR0_MASK;
                    end else begin
                        mask_q <= `PBAS_ZERO32;
                    end
                end else if (CE) begin
                    if (sel_boot && (g != 0)) begin
                        mask_q <= boot_mask;
                    end
                end
            end

            // attributes are read only from the bus side
            always @(posedge CLK or posedge RESET) begin
                if (RESET) begin
                    if (g == 0) begin
                        attr_q <= `PBAS_ATTR_IO_RST;
                    end else begin
                        attr_q <= `PBAS_ATTR_MEM_RST;
                    end
                end else if (CE) begin
                    if (sel_boot) begin
                        attr_q <= boot_attr;
                    end
                end
            end

            for (l = 0; l < LANES; l = l + 1) begin : lane
                reg [BYTE_W-1:0] byte_q;
                // a boot load clears the base and wins over a bus write in the same cycle
                always @(posedge CLK or posedge RESET) begin
                    if (RESET) begin
                        byte_q <= {BYTE_W{1'b0}};
                    end else if (CE) begin
                        if (sel_boot) begin
                            byte_q <= {BYTE_W{1'b0}};
                        end else if (sel_wr && CFG_BE[l]) begin
                            byte_q <= lane_write(CFG_WDATA, mask_q, l);
                        end
                    end
                end
                assign base_w[BYTE_W*l +: BYTE_W] = byte_q;
            end

            assign view_flat[REG_W*g +: REG_W] = bar_view(mask_q, base_w, attr_q);
            assign space_ok = (attr_q[`PBAS_BIT_SPACE] == ACC_IO);
            assign addr_ok = addr_match(ACC_ADDR, base_w, mask_q);
            // decode only enabled bits; alignment is left to configuration software
            assign ACC_HIT[g] = region_on(mask_q) && space_ok && addr_ok;
            assign pf_hit[g] = ACC_HIT[g] && !ACC_IO && attr_q[`PBAS_BIT_PF];
        end
    endgenerate

    assign any_pf = |pf_hit;
    assign ACC_BE_EFF = any_pf ? `PBAS_BE_ALL : ACC_BE;

    // out-of-range index reads zero
    always @* begin
        rd_view = `PBAS_ZERO32;
        if (CFG_IDX < NUM_BARS) begin
            rd_view = view_flat[REG_W*CFG_IDX +: REG_W];
        end
    end

    // one-cycle answer strobe
    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            CFG_RVALID <= 1'b0;
        end else if (CE) begin
            CFG_RVALID <= CFG_RD;
        end
    end

    // read data registered and held until the next read
    always @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            CFG_RDATA <= `PBAS_ZERO32;
        end else if (CE) begin
            if (CFG_RD) begin
                CFG_RDATA <= rd_view;
            end
        end
    end

endmodule

// File: sim/pbas_monitor.sv
`timescale 1ns/1ps
module pbas_monitor #(
    parameter NUM_BARS = 5
) (
    // clock, reset, enable
    input wire CLK,
    input wire RESET,
    input wire CE,
    // configuration reads
    input wire CFG_RD,
    input wire [2:0] CFG_IDX,
    input wire [31:0] CFG_RDATA,
    input wire CFG_RVALID,
    // access decode
    input wire ACC_IO,
    input wire [3:0] ACC_BE,
    input wire [NUM_BARS-1:0] ACC_HIT,
    input wire [3:0] ACC_BE_EFF
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    sequence rd_s; CE && CFG_RD; endsequence
    sequence ans_s; CFG_RVALID; endsequence
    read_answer_a: assert property (rd_s |=> ans_s) else $error("no answer");
    // a low clock enable holds an answer over the next edge
    answer_cause_a: assert property (ans_s |-> $past(CE && CFG_RD) || $past(!CE && CFG_RVALID))
        else $error("stray answer");
    type64_zero_a: assert property ((ans_s and !CFG_RDATA[0]) |-> !CFG_RDATA[2]) else $error("bit 2 set");
    reg0_pf_a: assert property ((ans_s and $past(CFG_IDX) == 3'h0) |-> !CFG_RDATA[3]) else $error("pf in 0");
    io_bit1_a: assert property ((ans_s and CFG_RDATA[0]) |-> !CFG_RDATA[1]) else $error("io bit 1");
    unmapped_zero_a: assert property ((ans_s and $past(CFG_IDX) >= NUM_BARS) |-> CFG_RDATA == 32'h0000_0000)
        else $error("unmapped");
    be_force_a: assert property (ACC_BE_EFF != ACC_BE |-> ACC_BE_EFF == 4'hF && |ACC_HIT && !ACC_IO)
        else $error("be forced");
    be_pass_a: assert property (!ACC_HIT |-> ACC_BE_EFF == ACC_BE) else $error("be changed");
endmodule
bind pbas_top pbas_monitor #(.NUM_BARS(NUM_BARS)) i_pbas_monitor (
    .CLK(CLK),
    .RESET(RESET),
    .CE(CE),
    .CFG_RD(CFG_RD),
    .CFG_IDX(CFG_IDX),
    .CFG_RDATA(CFG_RDATA),
    .CFG_RVALID(CFG_RVALID),
    .ACC_IO(ACC_IO),
    .ACC_BE(ACC_BE),
    .ACC_HIT(ACC_HIT),
    .ACC_BE_EFF(ACC_BE_EFF)
);

// File: sim/pbas_host.sv
`timescale 1ns/1ps
module pbas_host (
    // clock
    input wire CLK,
    // configuration cycles toward the device
    output reg CFG_WR = 1'b0,
    output reg CFG_RD = 1'b0,
    output reg [2:0] CFG_IDX = 3'h0,
    output reg [31:0] CFG_WDATA = 32'h0000_0000
);
    task cyc(input w, input [2:0] x, input [31:0] d);
        begin
            @(posedge CLK);
            CFG_WR <= w;
            CFG_RD <= !w;
            CFG_IDX <= x;
            CFG_WDATA <= d;
            @(posedge CLK);
            CFG_WR <= 1'b0;
            CFG_RD <= 1'b0;
            // released data must not keep looking valid
            CFG_WDATA <= ~d;
        end
    endtask
endmodule

// File: sim/pci_base_address_sizing_bench.sv
`timescale 1ns/1ps
module pci_base_address_sizing_bench;
    reg CLK = 1'b0, RESET = 1'b1, BOOT_WR = 1'b0, ACC_IO = 1'b0, CE = 1'b1;
    reg [2:0] BOOT_IDX = 3'h0;
    reg [3:0] ACC_BE = 4'h0;
    reg [3:0] CFG_BE = 4'hF;
    reg [31:0] BOOT_DATA = 32'h0000_0000, ACC_ADDR = 32'h0000_0000, seed = 32'h0001_4A0F, m, a, b;
    wire CFG_WR, CFG_RD, CFG_RVALID;
    wire [2:0] CFG_IDX;
    wire [31:0] CFG_WDATA, CFG_RDATA;
    wire [4:0] ACC_HIT;
    wire [3:0] ACC_BE_EFF;
    reg [31:0] q[$];
    integer miscompares = 0, samples_checked = 0, i;
    always #2.5 CLK = !CLK;
    pbas_host i_pbas_host (.*);
    pbas_top i_pbas_top (.*);
    function [31:0] xs(input [31:0] s);
        begin
            xs = s ^ (s << 13);
            xs = xs ^ (xs >> 17);
            xs = xs ^ (xs << 5);
        end
    endfunction
    task chk(input [39:0] n, input [31:0] e, input [31:0] g);
        begin
            samples_checked = samples_checked + 1;
            if (g !== e) begin
                miscompares = miscompares + 1;
                $display("wrong value %0s exp %h got %h", n, e, g);
            end
        end
    endtask
    task wr_rd(input [2:0] x, input [31:0] w, input [31:0] e);
        begin
            i_pbas_host.cyc(1'b1, x, w);
            q.push_back(e);
            i_pbas_host.cyc(1'b0, x, 32'h0000_0000);
        end
    endtask
    task complete_run;
        begin
            if (miscompares == 0 && samples_checked > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    always @(negedge CLK) if (CFG_RVALID === 1'b1) chk("rdata", q.pop_front(), CFG_RDATA);
    initial begin
        repeat (10) @(posedge CLK);
        RESET <= 1'b0;
        wr_rd(3'h0, 32'hFFFF_FFFF, 32'hFFFF_FF81);
        wr_rd(3'h0, 32'h0000_0300, 32'h0000_0301);
        // only the enabled byte lane takes the write
        CFG_BE <= 4'h2;
        wr_rd(3'h0, 32'hFFFF_FFFF, 32'h0000_FF01);
        CFG_BE <= 4'hF;
        wr_rd(3'h0, 32'h0000_0300, 32'h0000_0301);
        // let the answer strobe drop before freezing, or it would stand twice
        @(posedge CLK);
        CE <= 1'b0;
        i_pbas_host.cyc(1'b1, 3'h0, 32'hFFFF_FFFF);
        CE <= 1'b1;
        q.push_back(32'h0000_0301);
        i_pbas_host.cyc(1'b0, 3'h0, 32'h0000_0000);
        wr_rd(3'h5, 32'hFFFF_FFFF, 32'h0000_0000);
        for (i = 1; i < 5; i = i + 1) begin
            wr_rd(i, 32'hFFFF_FFFF, 32'h0000_0000);
            seed = xs(seed);
            m = 32'hFFFF_FFFF << (4 + seed[4:0] % 24);
            a = seed & 32'h0000_000E;
            @(posedge CLK);
            {BOOT_WR, BOOT_IDX, BOOT_DATA} <= {1'b1, i[2:0], m | a};
            @(posedge CLK);
            BOOT_WR <= 1'b0;
            wr_rd(i, 32'hFFFF_FFFF, m | (a & 32'h0000_000A));
            b = xs(seed ^ m);
            // top bits differ per register so regions never overlap
            b[31:29] = i;
            wr_rd(i, b, (b & m) | (a & 32'h0000_000A));
            {ACC_ADDR, ACC_BE} <= {(b & m) | (seed & ~m), b[3:0]};
            @(negedge CLK);
            chk("hit", 32'h1 << i, ACC_HIT);
            chk("be", a[3] ? 32'hF : b[3:0], ACC_BE_EFF);
        end
        @(posedge CLK);
        {ACC_IO, ACC_ADDR} <= {1'b1, 32'h0000_037F};
        @(negedge CLK);
        chk("iohit", 32'h1, ACC_HIT);
        repeat (3) @(posedge CLK);
        if (q.size() != 0) miscompares = miscompares + 1;
        complete_run;
    end
endmodule
